//--- rtl/ppfs_pkg.sv
// Purpose: constants and types for the port pin function selector
// Assumes: 32-bit APB, two 8-pin ports
// Notes: offsets are byte addresses of aligned words
package ppfs_pkg;
	localparam int PINS = 8;
	localparam logic [7:0] OFS_A_DIR = 8'h00;
	localparam logic [7:0] OFS_A_SEL = 8'h04;
	localparam logic [7:0] OFS_A_OUT = 8'h08;
	localparam logic [7:0] OFS_B_DIR = 8'h0C;
	localparam logic [7:0] OFS_B_SEL = 8'h10;
	localparam logic [7:0] OFS_B_OUT = 8'h14;
	localparam logic [7:0] OFS_PIN_IN = 8'h18;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [15:0] SEL_RST = 16'h0000;
	localparam logic [7:0] OUT_RST = 8'h00;
	localparam logic [1:0] SEL_GPIO = 2'h0;
	localparam logic [1:0] SEL_F1 = 2'h1;
	localparam logic [1:0] SEL_F2 = 2'h2;
	localparam logic [1:0] SEL_ANALOG = 2'h3;
	localparam int SER_HI = 4;
	localparam int PIN_SUBCLK = 0;
	localparam int PIN_AUXCLK = 1;
	localparam int PIN_TRIG = 2;
	localparam int PIN_TCK = 4;
	localparam int PIN_TMS = 5;
	localparam int PIN_TDI = 6;
	localparam int PIN_TDO = 7;
	localparam int PIN_A_CAP1 = 6;
	localparam int PIN_A_CAP2 = 7;
	localparam int PIN_B_CAP1 = 0;
	localparam int PIN_B_CAP2 = 1;
	localparam int PIN_B_MCLK = 6;
	localparam int PIN_B_XTAL = 7;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
	} ppfs_pad_t;

	// bit order ste, clk, rx/somi, tx/simo = bits 0..3
	typedef struct packed {
		logic [3:0] sig;
	} ppfs_serial_t;
endpackage : ppfs_pkg

//--- rtl/ppfs_top.sv
// Purpose: per-pin function multiplexer for two 8-pin ports
// Assumes: APB register access, one 25 MHz clock
// Notes: pin routing is combinational; pad inputs are synchronised
`timescale 1ns/100ps
`default_nettype none

module ppfs_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ppfs_pkg::ppfs_pad_t padIn,
	output ppfs_pkg::ppfs_pad_t padOut,
	output ppfs_pkg::ppfs_pad_t padOe,
	input wire logic testPortActive,
	input wire ppfs_pkg::ppfs_serial_t serialOut,
	input wire ppfs_pkg::ppfs_serial_t serialOe,
	output ppfs_pkg::ppfs_serial_t serialIn,
	input wire logic subsystemClockOut,
	input wire logic auxClockOut,
	input wire logic mainClockOut,
	input wire logic timerCompare1Out,
	input wire logic timerCompare2Out,
	input wire logic comparatorOut,
	output logic timerCapture1In,
	output logic timerCapture2In,
	output logic timerTriggerIn,
	output logic timerExtClockIn,
	output logic jtagTck,
	output logic jtagTms,
	output logic jtagTdi,
	input wire logic jtagTdo,
	output logic [7:0] analogEnable,
	output logic crystalInEnable,
	output logic crystalOutEnable
);
	logic rstMeta_n;
	logic rst_n;
	logic [15:0] padMeta_q;
	logic [15:0] padSync_q;
	logic [7:0] aDir_q;
	logic [15:0] aSel_q;
	logic [7:0] aOut_q;
	logic [7:0] bDir_q;
	logic [15:0] bSel_q;
	logic [7:0] bOut_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic mapped;
	logic wrEn;
	logic [7:0] pa;
	logic [7:0] pb;
	logic [3:0] sIn;
	logic [7:0] outA;
	logic [7:0] oeA;
	logic [7:0] outB;
	logic [7:0] oeB;

	function automatic logic [1:0] selOf(input logic [15:0] s, input int i);
		selOf = s[2 * i +: 2];
	endfunction : selOf

	// reset released through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rstMeta_n <= 1'b1;
			rst_n <= rstMeta_n;
		end
	end

	// pads are asynchronous to clk
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			padMeta_q <= 16'h0000;
			padSync_q <= 16'h0000;
		end else begin
			padMeta_q <= padIn;
			padSync_q <= padMeta_q;
		end
	end
	assign pa = padSync_q[15:8];
	assign pb = padSync_q[7:0];

	// zero wait states; data is prepared in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign wrEn = psel & penable & pwrite & mapped;

	always_comb begin
		mapped = 1'b1;
		rdata_d = 32'h0000_0000;
		case (paddr)
			ppfs_pkg::OFS_A_DIR: rdata_d[7:0] = aDir_q;
			ppfs_pkg::OFS_A_SEL: rdata_d[15:0] = aSel_q;
			ppfs_pkg::OFS_A_OUT: rdata_d[7:0] = aOut_q;
			ppfs_pkg::OFS_B_DIR: rdata_d[7:0] = bDir_q;
			ppfs_pkg::OFS_B_SEL: rdata_d[15:0] = bSel_q;
			ppfs_pkg::OFS_B_OUT: rdata_d[7:0] = bOut_q;
			ppfs_pkg::OFS_PIN_IN: rdata_d[15:0] = padSync_q;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (psel & ~penable) begin
			rdata_q <= rdata_d;
		end
	end
	assign prdata = rdata_q;

	// configuration registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aDir_q <= ppfs_pkg::DIR_RST;
			aSel_q <= ppfs_pkg::SEL_RST;
			aOut_q <= ppfs_pkg::OUT_RST;
			bDir_q <= ppfs_pkg::DIR_RST;
			bSel_q <= ppfs_pkg::SEL_RST;
			bOut_q <= ppfs_pkg::OUT_RST;
		end else if (wrEn) begin
			case (paddr)
				ppfs_pkg::OFS_A_DIR: aDir_q <= pwdata[7:0];
				ppfs_pkg::OFS_A_SEL: aSel_q <= pwdata[15:0];
				ppfs_pkg::OFS_A_OUT: aOut_q <= pwdata[7:0];
				ppfs_pkg::OFS_B_DIR: bDir_q <= pwdata[7:0];
				ppfs_pkg::OFS_B_SEL: bSel_q <= pwdata[15:0];
				ppfs_pkg::OFS_B_OUT: bOut_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// port A drive; each port has its own process, so local vectors keep one writer
	always_comb begin
		outA = 8'h00;
		oeA = 8'h00;
		for (int i = 0; i < ppfs_pkg::PINS; i++) begin
			case (selOf(aSel_q, i))
				ppfs_pkg::SEL_GPIO: begin
					outA[i] = aOut_q[i];
					oeA[i] = aDir_q[i];
				end
				ppfs_pkg::SEL_F1: begin
					outA[i] = serialOut.sig[i % ppfs_pkg::SER_HI];
					oeA[i] = serialOe.sig[i % ppfs_pkg::SER_HI];
				end
				ppfs_pkg::SEL_F2: begin
					oeA[i] = aDir_q[i] & (i == ppfs_pkg::PIN_SUBCLK
						|| i == ppfs_pkg::PIN_AUXCLK || i == ppfs_pkg::PIN_A_CAP1
						|| i == ppfs_pkg::PIN_A_CAP2);
					if (i == ppfs_pkg::PIN_SUBCLK)
						outA[i] = subsystemClockOut;
					else if (i == ppfs_pkg::PIN_AUXCLK)
						outA[i] = auxClockOut;
					else if (i == ppfs_pkg::PIN_A_CAP1)
						outA[i] = timerCompare1Out;
					else if (i == ppfs_pkg::PIN_A_CAP2)
						outA[i] = timerCompare2Out;
				end
				default: ;
			endcase
			if (testPortActive && i >= ppfs_pkg::PIN_TCK) begin
				outA[i] = (i == ppfs_pkg::PIN_TDO) ? jtagTdo : 1'b0;
				oeA[i] = (i == ppfs_pkg::PIN_TDO);
			end
		end
	end

	// port B drive; pins 2-5 have port I/O only
	always_comb begin
		outB = 8'h00;
		oeB = 8'h00;
		for (int i = 0; i < ppfs_pkg::PINS; i++) begin
			case (selOf(bSel_q, i))
				ppfs_pkg::SEL_GPIO: begin
					outB[i] = bOut_q[i];
					oeB[i] = bDir_q[i];
				end
				ppfs_pkg::SEL_F1: begin
					oeB[i] = bDir_q[i] & (i == ppfs_pkg::PIN_B_CAP1
						|| i == ppfs_pkg::PIN_B_CAP2 || i == ppfs_pkg::PIN_B_MCLK);
					if (i == ppfs_pkg::PIN_B_CAP1)
						outB[i] = timerCompare1Out;
					else if (i == ppfs_pkg::PIN_B_CAP2)
						outB[i] = timerCompare2Out;
					else if (i == ppfs_pkg::PIN_B_MCLK)
						outB[i] = mainClockOut;
				end
				ppfs_pkg::SEL_F2: begin
					if (i == ppfs_pkg::PIN_B_CAP1) begin
						outB[i] = comparatorOut;
						oeB[i] = bDir_q[i];
					end
				end
				default: ;
			endcase
		end
	end
	assign padOut = '{a: outA, b: outB};
	assign padOe = '{a: oeA, b: oeB};

	// inputs toward peripherals; undriven selections read as low
	always_comb begin
		for (int k = 0; k < ppfs_pkg::SER_HI; k++) begin
			if (selOf(aSel_q, k) == ppfs_pkg::SEL_F1)
				sIn[k] = pa[k];
			else if (selOf(aSel_q, k + ppfs_pkg::SER_HI) == ppfs_pkg::SEL_F1
				&& !testPortActive)
				sIn[k] = pa[k + ppfs_pkg::SER_HI];
			else
				sIn[k] = 1'b0;
		end
	end
	assign serialIn.sig = sIn;

	always_comb begin
		timerTriggerIn = (selOf(aSel_q, ppfs_pkg::PIN_TRIG) == ppfs_pkg::SEL_F2)
			& ~aDir_q[ppfs_pkg::PIN_TRIG] & pa[ppfs_pkg::PIN_TRIG];
		if (selOf(aSel_q, ppfs_pkg::PIN_A_CAP1) == ppfs_pkg::SEL_F2
			&& !aDir_q[ppfs_pkg::PIN_A_CAP1] && !testPortActive)
			timerCapture1In = pa[ppfs_pkg::PIN_A_CAP1];
		else
			timerCapture1In = (selOf(bSel_q, ppfs_pkg::PIN_B_CAP1) == ppfs_pkg::SEL_F1)
				& ~bDir_q[ppfs_pkg::PIN_B_CAP1] & pb[ppfs_pkg::PIN_B_CAP1];
		if (selOf(aSel_q, ppfs_pkg::PIN_A_CAP2) == ppfs_pkg::SEL_F2
			&& !aDir_q[ppfs_pkg::PIN_A_CAP2] && !testPortActive)
			timerCapture2In = pa[ppfs_pkg::PIN_A_CAP2];
		else
			timerCapture2In = (selOf(bSel_q, ppfs_pkg::PIN_B_CAP2) == ppfs_pkg::SEL_F1)
				& ~bDir_q[ppfs_pkg::PIN_B_CAP2] & pb[ppfs_pkg::PIN_B_CAP2];
		timerExtClockIn = (selOf(bSel_q, ppfs_pkg::PIN_B_XTAL) == ppfs_pkg::SEL_F1)
			& ~bDir_q[ppfs_pkg::PIN_B_XTAL] & pb[ppfs_pkg::PIN_B_XTAL];
	end

	assign jtagTck = testPortActive & pa[ppfs_pkg::PIN_TCK];
	assign jtagTms = testPortActive & pa[ppfs_pkg::PIN_TMS];
	assign jtagTdi = testPortActive & pa[ppfs_pkg::PIN_TDI];
	assign crystalOutEnable = (selOf(bSel_q, ppfs_pkg::PIN_B_MCLK) == ppfs_pkg::SEL_F2);
	assign crystalInEnable = (selOf(bSel_q, ppfs_pkg::PIN_B_XTAL) == ppfs_pkg::SEL_F2);

	always_comb begin
		for (int i = 0; i < ppfs_pkg::PINS; i++)
			analogEnable[i] = (selOf(aSel_q, i) == ppfs_pkg::SEL_ANALOG)
				&& !(testPortActive && i >= ppfs_pkg::PIN_TCK);
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	gpio_drive_a: assert property ((aSel_q[1:0] == ppfs_pkg::SEL_GPIO) |->
		(padOe.a[0] == aDir_q[0] && padOut.a[0] == aOut_q[0]))
		else $error("port A pin 0 port I/O drive wrong");
	serial_route_a: assert property ((aSel_q[7:6] == ppfs_pkg::SEL_F1) |->
		(padOe.a[3] == serialOe.sig[3] && padOut.a[3] == serialOut.sig[3]))
		else $error("serial transmit not routed to pin 3");
	subclk_out_a: assert property ((aSel_q[1:0] == ppfs_pkg::SEL_F2) |->
		(padOe.a[0] == aDir_q[0]))
		else $error("subsystem clock drive wrong");
	analog_hand_a: assert property ((aSel_q[5:4] == ppfs_pkg::SEL_ANALOG) |->
		(analogEnable[2] && !padOe.a[2]))
		else $error("analog pin still driven");
	test_port_a: assert property (testPortActive |->
		(padOe.a[7:4] == 4'h8 && padOut.a[7] == jtagTdo))
		else $error("test port override wrong");
	capture_in_a: assert property ((aSel_q[13:12] == ppfs_pkg::SEL_F2 && !aDir_q[6]
		&& !testPortActive) |-> (timerCapture1In == pa[6]))
		else $error("capture 1 not from port A pin 6");
	trigger_in_a: assert property ((aSel_q[5:4] == ppfs_pkg::SEL_F2 && !aDir_q[2]) ##1
		$changed(pa[2]) |-> timerTriggerIn == pa[2])
		else $error("trigger not following pin");
	comp_out_a: assert property ((bSel_q[1:0] == ppfs_pkg::SEL_F2 && bDir_q[0]) |->
		(padOe.b[0] && padOut.b[0] == comparatorOut))
		else $error("comparator output not driven");
	xtal_sel_a: assert property ((bSel_q[13:12] == ppfs_pkg::SEL_F2) |->
		(crystalOutEnable && !padOe.b[6]))
		else $error("crystal out pin wrong");
	ext_clock_a: assert property ((bSel_q[15:14] == ppfs_pkg::SEL_F1 && !bDir_q[7]) |->
		(timerExtClockIn == pb[7]))
		else $error("timer clock input wrong");
	reset_clear_a: assert property ($rose(rst_n) |-> (aSel_q == ppfs_pkg::SEL_RST
		&& bDir_q == ppfs_pkg::DIR_RST))
		else $error("configuration not cleared by reset");
	cov_serial: cover property (aSel_q[7:0] == 8'h55);
	cov_test_port: cover property (testPortActive && aSel_q[15:8] != 8'h00);
	cov_crystal: cover property (crystalInEnable && crystalOutEnable);
endmodule : ppfs_top

`default_nettype wire

//--- verif/ppfs_far_model.sv
// Purpose: board side of the pads, resolving each pin level
// Assumes: no pull resistors on any pin
// Notes: an undriven pin shows only what the board applies
`timescale 1ns/100ps
`default_nettype none
module ppfs_far_model (
	input wire ppfs_pkg::ppfs_pad_t padOut,
	input wire ppfs_pkg::ppfs_pad_t padOe,
	input wire ppfs_pkg::ppfs_pad_t boardLevel,
	output ppfs_pkg::ppfs_pad_t padIn
);
	// device drive wins; contention is not modelled
	assign padIn = (padOe & padOut) | (~padOe & boardLevel);
endmodule : ppfs_far_model
`default_nettype wire

//--- verif/ppfs_top_test.sv
// Purpose: directed bench for the port pin function selector
// Assumes: zero-wait APB slave, pad inputs synchronised by two flops
// Notes: checks after settle sample on the falling edge, after pad sync has settled
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module ppfs_top_test;
	logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, slvErr, testPortActive = 1'b0, jtagTdo = 1'b0;
	ppfs_pkg::ppfs_pad_t padIn, padOut, padOe, boardLevel = 16'h0000;
	ppfs_pkg::ppfs_serial_t serialOut = 4'h0, serialOe = 4'h0, serialIn;
	logic subsystemClockOut = 1'b0, auxClockOut = 1'b0, mainClockOut = 1'b0;
	logic timerCompare1Out = 1'b0, timerCompare2Out = 1'b0, comparatorOut = 1'b0;
	logic timerCapture1In, timerCapture2In, timerTriggerIn, timerExtClockIn;
	logic jtagTck, jtagTms, jtagTdi, crystalInEnable, crystalOutEnable;
	logic [7:0] analogEnable;
	int errTotal = 0, nCompared = 0, cycles = 0;

	ppfs_top DUT (.clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .padIn, .padOut, .padOe, .testPortActive, .serialOut,
		.serialOe, .serialIn, .subsystemClockOut, .auxClockOut, .mainClockOut,
		.timerCompare1Out, .timerCompare2Out, .comparatorOut, .timerCapture1In,
		.timerCapture2In, .timerTriggerIn, .timerExtClockIn, .jtagTck, .jtagTms,
		.jtagTdi, .jtagTdo, .analogEnable, .crystalInEnable, .crystalOutEnable);
	ppfs_far_model board (.padOut(padOut), .padOe(padOe), .boardLevel(boardLevel),
		.padIn(padIn));

	always #20 clk = ~clk;

	task giveVerdict;
		if (errTotal == 0 && nCompared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : giveVerdict

	// run is about 140 cycles; ceiling leaves wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles > 4000) begin
			errTotal++;
			giveVerdict;
		end
	end

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task settle;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task testReset;
		apb(1'b0, ppfs_pkg::OFS_A_SEL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, ppfs_pkg::OFS_B_DIR, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(padOe, 16'h0000)
	endtask : testReset

	task testGpio;
		wr(ppfs_pkg::OFS_A_DIR, 32'hFF);
		wr(ppfs_pkg::OFS_A_OUT, 32'h5A);
		wr(ppfs_pkg::OFS_B_DIR, 32'h0F);
		wr(ppfs_pkg::OFS_B_OUT, 32'hA5);
		boardLevel <= 16'h3CC3;
		settle;
		`CHK(padOe, 16'hFF0F)
		`CHK(padOut.a, 8'h5A)
		wr(ppfs_pkg::OFS_A_DIR, 32'h00);
		settle;
		apb(1'b0, ppfs_pkg::OFS_PIN_IN, 32'h0);
		`CHK(rd, 32'h3CC5)
		wr(ppfs_pkg::OFS_B_DIR, 32'h00);
	endtask : testGpio

	task testSerial;
		serialOut <= 4'hA;
		serialOe <= 4'h6;
		boardLevel <= 16'h0900;
		wr(ppfs_pkg::OFS_A_DIR, 32'hFF);
		wr(ppfs_pkg::OFS_A_SEL, 32'h5555);
		settle;
		`CHK(padOe.a, 8'h66)
		`CHK(padOut.a & 8'h66, 8'h22)
		`CHK(serialIn, 4'hB)
	endtask : testSerial

	task testTimerA;
		@(posedge clk);
		subsystemClockOut <= 1'b1;
		timerCompare2Out <= 1'b1;
		boardLevel <= 16'h4400;
		wr(ppfs_pkg::OFS_A_DIR, 32'h83);
		wr(ppfs_pkg::OFS_A_SEL, 32'hA02A);
		settle;
		`CHK(padOe.a, 8'h83)
		`CHK(padOut.a & 8'h83, 8'h81)
		`CHK({timerTriggerIn, timerCapture1In}, 2'b11)
		@(posedge clk);
		timerCompare1Out <= 1'b1;
		boardLevel <= 16'h8000;
		wr(ppfs_pkg::OFS_A_DIR, 32'h40);
		settle;
		`CHK(padOe.a, 8'h40)
		`CHK({padOut.a[6], timerCapture2In, timerTriggerIn}, 3'b110)
	endtask : testTimerA

	task testAnalogJtag;
		@(posedge clk);
		jtagTdo <= 1'b1;
		boardLevel <= 16'h7000;
		wr(ppfs_pkg::OFS_A_DIR, 32'hFF);
		wr(ppfs_pkg::OFS_A_SEL, 32'hFFFF);
		settle;
		`CHK(padOe.a, 8'h00)
		`CHK(analogEnable, 8'hFF)
		@(posedge clk);
		testPortActive <= 1'b1;
		settle;
		`CHK(analogEnable, 8'h0F)
		`CHK({padOe.a, padOut.a[7]}, 9'h101)
		`CHK({jtagTck, jtagTms, jtagTdi}, 3'b111)
		@(posedge clk);
		testPortActive <= 1'b0;
		settle;
		`CHK({jtagTck, jtagTms, jtagTdi}, 3'b000)
		wr(ppfs_pkg::OFS_A_SEL, 32'h0);
		wr(ppfs_pkg::OFS_A_DIR, 32'h0);
	endtask : testAnalogJtag

	task testPortB;
		mainClockOut <= 1'b1;
		boardLevel <= 16'h0082;
		wr(ppfs_pkg::OFS_B_DIR, 32'h41);
		wr(ppfs_pkg::OFS_B_SEL, 32'h5005);
		settle;
		`CHK(padOe.b, 8'h41)
		`CHK(padOut.b & 8'h41, 8'h41)
		`CHK({timerCapture2In, timerExtClockIn}, 2'b11)
		@(posedge clk);
		timerCompare1Out <= 1'b0;
		comparatorOut <= 1'b1;
		wr(ppfs_pkg::OFS_B_SEL, 32'hA002);
		settle;
		`CHK(padOut.b[0], 1'b1)
		`CHK({crystalInEnable, crystalOutEnable}, 2'b11)
	endtask : testPortB

	task testUnmapped;
		wr(8'h1C, 32'hFFFF_FFFF);
		`CHK(slvErr, 1'b1)
		apb(1'b0, 8'h1C, 32'h0);
		`CHK({slvErr, rd}, {1'b1, 32'h0})
		apb(1'b0, ppfs_pkg::OFS_B_SEL, 32'h0);
		`CHK({slvErr, rd}, {1'b0, 32'hA002})
	endtask : testUnmapped

	// reset in mid-run must clear a configuration that is not all zero
	task testMidReset;
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK({padOe, crystalInEnable, crystalOutEnable}, 18'h00000)
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, ppfs_pkg::OFS_B_SEL, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, ppfs_pkg::OFS_B_DIR, 32'h0);
		`CHK(rd, 32'h0)
		`CHK({padOe, padOut}, 32'h0)
	endtask : testMidReset

	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		testReset;
		testGpio;
		testSerial;
		testTimerA;
		testAnalogJtag;
		testPortB;
		testUnmapped;
		testMidReset;
		giveVerdict;
	end
endmodule : ppfs_top_test
`default_nettype wire
